//--- verilog/ssd_slice_shift_dest_control.v
// Shifter, Q register and destination control of a four-bit ALU slice
// Summary of operation
// - Four-bit Q register updates on rising clock; loads F, feeds S operand.
// - Q shifter does logical up or down shifts only.
// - Q up takes low Q pin in, drives Q3; down takes high pin, drives Q0.
// - Destination codes apply when any of bits 0..4 high and enable low.
// - Code 0 arithmetic down; top slice keeps F3, serial input to Y2.
// - Code 1 logical down everywhere; F0 out low, Q holds, RAM written.
// - Codes 2,3 shift result down and Q logically down, RAM written.
// - Code 8 arithmetic up; top slice keeps F3, outputs F2 high.
// - Code 9 logical up, Q held; A,B shift up with Q up.
// - Code 4 passes F, writes RAM, holds Q, parity out low.
// - Code 5 passes F, no RAM write, parity out, Q shifts down.
// - Codes 6,7 load Q with F, pass F, parity; 7 writes RAM.
// - Codes C,D pass F, no write, low ALU pin floats; D shifts Q up.
// - Code E drives low serial input onto all Y bits and high pin.
// - Parity is XOR of four result bits and high ALU serial input.
// - Y and operand B buffers drive only while their low-active enables are low.
// - Open-drain zero line signals all four Y pins low.
// - Write strobe goes low when the instruction writes the RAM.
// - Strobe goes low, and Q and sign-compare flop change, only while enable is low.
// - Single shifts write with Q unchanged; double shift Q; Q-only no write.
`include "ssd_defs.vh"
module ssd_slice_shift_dest_control #(
  parameter WIDTH = 4
) (
  input wire clock,
  input wire resetn,
  input wire [8:0] instruction_bits,
  input wire instruction_enable_n,
  input wire lowest_slice_select_n,
  input wire [WIDTH-1:0] alu_result,
  input wire sign_compare_d,
  input wire [WIDTH-1:0] operand_b_value,
  input wire y_oe_n,
  input wire operand_b_oe_n,
  input wire [WIDTH-1:0] y_in,
  input wire alu_serial_low_in,
  input wire alu_serial_high_in,
  input wire qreg_serial_low_in,
  input wire qreg_serial_high_in,
  input wire ram_write_or_position_in,
  output reg [WIDTH-1:0] y_out,
  output reg [WIDTH-1:0] y_oe,
  output reg [WIDTH-1:0] operand_b_port_out,
  output reg [WIDTH-1:0] operand_b_port_oe,
  output reg alu_serial_low_out,
  output reg alu_serial_low_oe,
  output reg alu_serial_high_out,
  output reg alu_serial_high_oe,
  output reg qreg_serial_low_out,
  output reg qreg_serial_low_oe,
  output reg qreg_serial_high_out,
  output reg qreg_serial_high_oe,
  output reg zero_out,
  output reg zero_oe,
  output reg ram_write_or_position_out,
  output reg ram_write_or_position_oe,
  output reg ram_write_n,
  output reg [WIDTH-1:0] q_value,
  output reg sign_compare_q
);
  // Pin synchronisers, two stages each
  reg [WIDTH-1:0] y_in_s1_q;
  reg [WIDTH-1:0] y_in_s2_q;
  reg [3:0] ser_s1_q;
  reg [3:0] ser_s2_q;
  reg [1:0] pos_s1_q;
  reg [1:0] pos_s2_q;
  always @(posedge clock) begin
    y_in_s1_q <= y_in;
    y_in_s2_q <= y_in_s1_q;
    ser_s1_q <= {alu_serial_low_in, alu_serial_high_in, qreg_serial_low_in,
      qreg_serial_high_in};
    ser_s2_q <= ser_s1_q;
    pos_s1_q <= {lowest_slice_select_n, ram_write_or_position_in};
    pos_s2_q <= pos_s1_q;
  end

  wire alu_serial_low_i = ser_s2_q[3];
  wire alu_serial_high_i = ser_s2_q[2];
  wire qreg_serial_low_i = ser_s2_q[1];
  wire qreg_serial_high_i = ser_s2_q[0];
  wire is_lowest = ~pos_s2_q[1];
  wire is_top = pos_s2_q[1] & ~pos_s2_q[0];
  wire [3:0] dest = instruction_bits[8:5];
  wire dest_mode = (|instruction_bits[4:0]) & ~instruction_enable_n;
  wire [3:0] f = alu_result;
  wire parity;

  ssd_parity u_parity (
    .f(f),
    .serial_in(alu_serial_high_i),
    .parity(parity)
  );

  // Destination decode
  reg [3:0] y_d;
  reg alu_serial_low_d;
  reg alu_serial_low_en_d;
  reg alu_serial_high_d;
  reg alu_serial_high_en_d;
  reg wr_d;
  reg [1:0] qop;
  always @* begin
    y_d = f;
    alu_serial_low_d = 1'b0;
    alu_serial_low_en_d = 1'b0;
    alu_serial_high_d = 1'b0;
    alu_serial_high_en_d = 1'b0;
    wr_d = 1'b0;
    qop = `SSD_QOP_HOLD;
    if (dest_mode) begin
      case (dest)
        `SSD_DEST_ARDN_HOLD, `SSD_DEST_ARDN_QDN: begin
          y_d = is_top ? {f[3], alu_serial_high_i, f[2:1]} : {alu_serial_high_i, f[3:1]};
          alu_serial_low_d = f[0];
          alu_serial_low_en_d = 1'b1;
          wr_d = 1'b1;
          qop = dest[1] ? `SSD_QOP_DOWN : `SSD_QOP_HOLD;
        end
        `SSD_DEST_LGDN_HOLD, `SSD_DEST_LGDN_QDN: begin
          y_d = {alu_serial_high_i, f[3:1]};
          alu_serial_low_d = f[0];
          alu_serial_low_en_d = 1'b1;
          wr_d = 1'b1;
          qop = dest[1] ? `SSD_QOP_DOWN : `SSD_QOP_HOLD;
        end
        `SSD_DEST_PASS_HOLD, `SSD_DEST_PASS_QDN, `SSD_DEST_LOADQ_NOWR,
        `SSD_DEST_LOADQ_WR: begin
          alu_serial_low_d = parity;
          alu_serial_low_en_d = 1'b1;
          wr_d = (dest == `SSD_DEST_PASS_HOLD) | (dest == `SSD_DEST_LOADQ_WR);
          if (dest == `SSD_DEST_PASS_QDN)
            qop = `SSD_QOP_DOWN;
          else if (dest[1])
            qop = `SSD_QOP_LOAD;
        end
        `SSD_DEST_ARUP_HOLD, `SSD_DEST_ARUP_QUP: begin
          y_d = is_top ? {f[3], f[1:0], alu_serial_low_i} : {f[2:0], alu_serial_low_i};
          alu_serial_high_d = is_top ? f[2] : f[3];
          alu_serial_high_en_d = 1'b1;
          wr_d = 1'b1;
          qop = dest[1] ? `SSD_QOP_UP : `SSD_QOP_HOLD;
        end
        `SSD_DEST_LGUP_HOLD, `SSD_DEST_LGUP_QUP: begin
          y_d = {f[2:0], alu_serial_low_i};
          alu_serial_high_d = f[3];
          alu_serial_high_en_d = 1'b1;
          wr_d = 1'b1;
          qop = dest[1] ? `SSD_QOP_UP : `SSD_QOP_HOLD;
        end
        `SSD_DEST_PASS_NOWR, `SSD_DEST_QUP_NOWR: begin
          qop = dest[0] ? `SSD_QOP_UP : `SSD_QOP_HOLD;
        end
        `SSD_DEST_SIGNEXT: begin
          y_d = {4{alu_serial_low_i}};
          alu_serial_high_d = alu_serial_low_i;
          alu_serial_high_en_d = 1'b1;
          wr_d = 1'b1;
        end
        default: begin
          wr_d = 1'b1;
        end
      endcase
    end
  end

  // Q shifter, logical only; serial pins per direction
  reg [3:0] q_d;
  always @* begin
    case (qop)
      `SSD_QOP_DOWN: q_d = {qreg_serial_high_i, q_value[3:1]};
      `SSD_QOP_UP: q_d = {q_value[2:0], qreg_serial_low_i};
      `SSD_QOP_LOAD: q_d = f;
      default: q_d = q_value;
    endcase
  end

  wire any_y_low_n = |(y_oe_n ? y_in_s2_q : y_out);

  always @(posedge clock) begin
    if (!resetn) begin
      y_out <= 4'h0;
      y_oe <= 4'h0;
      operand_b_port_out <= 4'h0;
      operand_b_port_oe <= 4'h0;
      alu_serial_low_out <= 1'b0;
      alu_serial_low_oe <= 1'b0;
      alu_serial_high_out <= 1'b0;
      alu_serial_high_oe <= 1'b0;
      qreg_serial_low_out <= 1'b0;
      qreg_serial_low_oe <= 1'b0;
      qreg_serial_high_out <= 1'b0;
      qreg_serial_high_oe <= 1'b0;
      zero_out <= 1'b0;
      zero_oe <= 1'b0;
      ram_write_or_position_out <= 1'b1;
      ram_write_or_position_oe <= 1'b0;
      ram_write_n <= 1'b1;
      q_value <= `SSD_Q_RESET;
      sign_compare_q <= 1'b0;
    end else begin
      y_out <= y_d;
      y_oe <= {WIDTH{~y_oe_n}};
      operand_b_port_out <= operand_b_value;
      operand_b_port_oe <= {WIDTH{~operand_b_oe_n}};
      alu_serial_low_out <= alu_serial_low_d;
      alu_serial_low_oe <= alu_serial_low_en_d;
      alu_serial_high_out <= alu_serial_high_d;
      alu_serial_high_oe <= alu_serial_high_en_d;
      qreg_serial_low_out <= q_value[0];
      qreg_serial_low_oe <= (qop == `SSD_QOP_DOWN);
      qreg_serial_high_out <= q_value[3];
      qreg_serial_high_oe <= (qop == `SSD_QOP_UP);
      zero_out <= 1'b0;
      zero_oe <= any_y_low_n;
      ram_write_n <= ~(wr_d & ~instruction_enable_n);
      ram_write_or_position_out <= ~(wr_d & ~instruction_enable_n);
      ram_write_or_position_oe <= is_lowest;
      if (!instruction_enable_n) begin
        q_value <= q_d;
        sign_compare_q <= sign_compare_d;
      end
    end
  end
endmodule // ssd_slice_shift_dest_control

//--- verilog/ssd_defs.vh
// Constants for the slice shifter and destination control block
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH
`define SSD_DEST_ARDN_HOLD 4'h0
`define SSD_DEST_LGDN_HOLD 4'h1
`define SSD_DEST_ARDN_QDN 4'h2
`define SSD_DEST_LGDN_QDN 4'h3
`define SSD_DEST_PASS_HOLD 4'h4
`define SSD_DEST_PASS_QDN 4'h5
`define SSD_DEST_LOADQ_NOWR 4'h6
`define SSD_DEST_LOADQ_WR 4'h7
`define SSD_DEST_ARUP_HOLD 4'h8
`define SSD_DEST_LGUP_HOLD 4'h9
`define SSD_DEST_ARUP_QUP 4'hA
`define SSD_DEST_LGUP_QUP 4'hB
`define SSD_DEST_PASS_NOWR 4'hC
`define SSD_DEST_QUP_NOWR 4'hD
`define SSD_DEST_SIGNEXT 4'hE
`define SSD_DEST_PASS_WR 4'hF
`define SSD_QOP_HOLD 2'h0
`define SSD_QOP_DOWN 2'h1
`define SSD_QOP_UP 2'h2
`define SSD_QOP_LOAD 2'h3
`define SSD_Q_RESET 4'h0
`endif

//--- verilog/ssd_parity.v
// Five-input parity for the low ALU serial pin
module ssd_parity (
  input wire [3:0] f,
  input wire serial_in,
  output wire parity
);
  assign parity = ^f ^ serial_in;
endmodule // ssd_parity

//--- dv/ssd_chk_sva.sv
// Assertion checker for the slice destination control block
module ssd_chk (
  input wire clock,
  input wire resetn,
  input wire [8:0] instruction_bits,
  input wire instruction_enable_n,
  input wire [3:0] alu_result,
  input wire y_oe_n,
  input wire [3:0] y_out,
  input wire [3:0] y_oe,
  input wire alu_serial_low_oe,
  input wire qreg_serial_high_oe,
  input wire ram_write_n,
  input wire [3:0] q_value,
  input wire sign_compare_q
);
  wire en = !instruction_enable_n && |instruction_bits[4:0];
  wire [3:0] d = instruction_bits[8:5];
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_hold_disabled: assert property (
    instruction_enable_n |=> ram_write_n && $stable(q_value) && $stable(sign_compare_q))
    else $error("state moved while disabled");
  chk_special_mode: assert property (
    !instruction_enable_n && !(|instruction_bits[4:0]) |=> ram_write_n && $stable(q_value))
    else $error("special mode wrote");
  chk_write_decode: assert property (
    en |=> ram_write_n == $past(d == 4'h5 || d == 4'h6 || d == 4'hC || d == 4'hD))
    else $error("write strobe wrong");
  chk_q_load: assert property (
    en && d == 4'h6 |=> q_value == $past(alu_result))
    else $error("q load wrong");
  chk_q_down: assert property (
    en && d == 4'h5 |=> q_value[2:0] == $past(q_value[3:1]))
    else $error("q down wrong");
  chk_pass_f: assert property (
    en && d == 4'hF |=> y_out == $past(alu_result) && !alu_serial_low_oe)
    else $error("pass code wrong");
  chk_parity_drive: assert property (
    en && d[3:2] == 2'b01 |=> alu_serial_low_oe && !qreg_serial_high_oe)
    else $error("parity pin not driven");
  chk_y_enable: assert property (
    1'b1 |=> y_oe == {4{!$past(y_oe_n)}})
    else $error("y enable wrong");
endmodule // ssd_chk
bind ssd_slice_shift_dest_control ssd_chk u_chk (.*);

//--- dv/ssd_far_model.sv
// Neighbouring slices and strapping around one slice
module ssd_far_model (
  input wire [3:0] y_out,
  input wire [3:0] y_oe,
  input wire alu_serial_low_out,
  input wire alu_serial_low_oe,
  input wire alu_serial_high_out,
  input wire alu_serial_high_oe,
  input wire qreg_serial_low_out,
  input wire qreg_serial_low_oe,
  input wire qreg_serial_high_out,
  input wire qreg_serial_high_oe,
  input wire ram_write_or_position_out,
  input wire ram_write_or_position_oe,
  input wire strap_top,
  output wire [3:0] y_in,
  output wire alu_serial_low_in,
  output wire alu_serial_high_in,
  output wire qreg_serial_low_in,
  output wire qreg_serial_high_in,
  output wire ram_write_or_position_in,
  output wire lowest_slice_select_n
);
  // Released Y bits show the inverse; neighbours shift 1 in from above, 0 from below
  assign y_in = ~(y_out ^ y_oe);
  assign alu_serial_low_in = alu_serial_low_oe ? alu_serial_low_out : 1'b0;
  assign alu_serial_high_in = alu_serial_high_oe ? alu_serial_high_out : 1'b1;
  assign qreg_serial_low_in = qreg_serial_low_oe ? qreg_serial_low_out : 1'b0;
  assign qreg_serial_high_in = qreg_serial_high_oe ? qreg_serial_high_out : 1'b1;
  // Strapped as lowest slice, or as top slice with the position pin tied low
  assign lowest_slice_select_n = strap_top;
  assign ram_write_or_position_in = ram_write_or_position_oe ? ram_write_or_position_out :
    ~strap_top;
endmodule // ssd_far_model

//--- dv/tb_top.sv
// Self-checking bench for the slice destination control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] YTBL = 64'hDDDD_AAAA_4444_AA0A;
  localparam logic [15:0] NOWR = 16'h3060;
  logic clock = 0, resetn = 0, instruction_enable_n = 1, sign_compare_d = 0;
  logic y_oe_n = 0, operand_b_oe_n = 1, strap_top = 0;
  logic [8:0] instruction_bits = 9'h001;
  logic [3:0] alu_result = 4'h0, operand_b_value = 4'h0;
  wire [3:0] y_in, y_out, y_oe, operand_b_port_out, operand_b_port_oe, q_value;
  wire alu_serial_low_in, alu_serial_high_in, qreg_serial_low_in, qreg_serial_high_in;
  wire ram_write_or_position_in, lowest_slice_select_n, alu_serial_low_out, alu_serial_low_oe;
  wire alu_serial_high_out, alu_serial_high_oe, qreg_serial_low_out, qreg_serial_low_oe;
  wire qreg_serial_high_out, qreg_serial_high_oe, zero_out, zero_oe, ram_write_n;
  wire ram_write_or_position_out, ram_write_or_position_oe, sign_compare_q;
  int fail_count = 0;
  int checks = 0;
  ssd_slice_shift_dest_control u_dut (.*);
  ssd_far_model u_far (.*);
  initial forever #4 clock = ~clock;
  task automatic chk(string n, logic [3:0] e, logic [3:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(logic [3:0] d, logic n, logic [3:0] f, logic [4:0] s = 5'h01);
    instruction_bits = {d, s};
    instruction_enable_n = n;
    alu_result = f;
    sign_compare_d = f[0];
    operand_b_value = ~f;
    @(posedge clock);
    #1;
  endtask
  task automatic t_qreg;
    step(4'h6, 0, 4'hA);
    chk("q load", 4'hA, q_value);
    step(4'h5, 0, 4'h0);
    chk("q down", 4'hD, q_value);
    step(4'hD, 0, 4'h0);
    chk("q up", 4'hA, q_value);
    step(4'h6, 1, 4'h5);
    chk("q disabled", 4'hA, q_value);
    chk("sign hold", 4'h0, {3'h0, sign_compare_q});
    step(4'h7, 0, 4'h5, 5'h00);
    chk("strobe special", 4'h1, {3'h0, ram_write_n});
    step(4'hF, 0, 4'h3);
    chk("pass", 4'h3, y_out);
    chk("sign load", 4'h1, {3'h0, sign_compare_q});
  endtask
  task automatic t_top;
    strap_top = 1;
    repeat (5) step(4'h0, 0, 4'h2);
    chk("top down", 4'h5, y_out);
    repeat (5) step(4'h8, 0, 4'h5);
    chk("top up", 4'h2, y_out);
    chk("top alu_serial_high", 4'h1, {3'h0, alu_serial_high_out});
    chk("pos oe", 4'h0, {3'h0, ram_write_or_position_oe});
    y_oe_n = 1;
    repeat (5) step(4'hF, 0, 4'hF);
    chk("y float", 4'h0, y_oe);
    chk("zero ext", 4'h0, {3'h0, zero_oe});
    y_oe_n = 0;
    strap_top = 0;
  endtask
  task automatic t_codes;
    logic [3:0] e;
    for (int c = 0; c < 16; c++) begin
      operand_b_oe_n = c[0];
      repeat (5) step(c[3:0], 0, 4'hA);
      e = YTBL[63 - 4 * c -: 4];
      chk("y out", e, y_out);
      chk("strobe", {3'h0, NOWR[c]}, {3'h0, ram_write_n});
      chk("zero", {3'h0, e != 4'h0}, {3'h0, zero_oe});
      chk("zero level", 4'h0, {3'h0, zero_out});
      chk("b data", 4'h5, operand_b_port_out);
      chk("pos write", {3'h0, NOWR[c]}, {3'h0, ram_write_or_position_out});
      chk("pos oe", 4'h1, {3'h0, ram_write_or_position_oe});
      chk("b enable", {4{~c[0]}}, operand_b_port_oe);
      if (c inside {[4:7]}) chk("parity", 4'h1, {3'h0, alu_serial_low_out});
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    chk("q reset", 4'h0, q_value);
    chk("strobe reset", 4'h1, {3'h0, ram_write_n});
    resetn = 1;
    repeat (3) step(4'h0, 1, 4'h0);
    t_qreg();
    t_codes();
    t_top();
    stop_test();
  end
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule // tb_top
